/* verilog/nas_pkg.sv */
// shared types and constants of the nibble alu with skip logic
// assumes a decoder that presents one decoded operation per cycle
package nas_pkg;

  // operation codes presented by the decoder
  typedef enum logic [4:0] {
    NAS_NOP,
    NAS_ADDS_A_IMM,   // accumulator add immediate, skip on carry
    NAS_ADDS_RP1_XA,  // pair plus wide pair, skip on carry
    NAS_ADD_WITH_CARRY_FLAG_A_MEM,
    NAS_ADD_WITH_CARRY_FLAG_XA_RP,
    NAS_ADD_WITH_CARRY_FLAG_RP1_XA,
    NAS_SUBTRACT_SKIP_ON_BORROW_A_MEM,
    NAS_SUBTRACT_SKIP_ON_BORROW_XA_RP,
    NAS_SUBTRACT_SKIP_ON_BORROW_RP1_XA,
    NAS_SUBTRACT_WITH_BORROW_A_MEM,
    NAS_SUBTRACT_WITH_BORROW_XA_RP,
    NAS_SUBTRACT_WITH_BORROW_RP1_XA,
    NAS_AND_A,
    NAS_AND_XA_RP,
    NAS_AND_RP1_XA,
    NAS_OR_A,
    NAS_OR_XA_RP,
    NAS_OR_RP1_XA,
    NAS_XOR_A,
    NAS_XOR_XA_RP,
    NAS_XOR_RP1_XA,
    NAS_ROTATE_RIGHT,
    NAS_COMPLEMENT,
    NAS_INCREMENT_AND_SKIP_REG,
    NAS_INCREMENT_AND_SKIP_PAIR,
    NAS_INCREMENT_AND_SKIP_MEM,
    NAS_DECREMENT_AND_SKIP_REG,
    NAS_DECREMENT_AND_SKIP_PAIR,
    NAS_SKE_REG
  } nas_op_e;

  // one decoded request
  typedef struct packed {
    logic       valid;
    nas_op_e    op;
    logic       imm_sel;   // logical ops on a: immediate instead of memory
    logic [3:0] nibble;    // nibble_immediate, single register or memory
    logic [7:0] acc_pair;  // wide_accumulator_pair contents
    logic [7:0] pair;      // any_register_pair or pair_except_accumulator
  } nas_req_s;

  // one result, registered
  typedef struct packed {
    logic       valid;
    logic [7:0] result;    // low nibble only for 4-bit forms
    logic       wide;      // result is 8 bits
    logic       carry_we;
    logic       carry_flag;
    logic       skip;
  } nas_res_s;

  localparam logic       NAS_CARRY_RST = 1'b0;
  localparam logic [3:0] NAS_NIB_ALL1  = 4'hf;
  localparam logic [7:0] NAS_PAIR_ALL1 = 8'hff;
  localparam logic [3:0] NAS_NIB_ZERO  = 4'h0;
  localparam logic [7:0] NAS_PAIR_ZERO = 8'h00;

endpackage

/* verilog/nas_alu.sv */
// nibble alu with skip request and carry flag for a 4-bit core
// assumes the sequencer suppresses the instruction after a skip request
// Contract
// - pair plus wide pair skip form: skip on carry, carry flag untouched
// - add with carry: sum plus flag, flag set on carry else cleared
// - add with carry of accumulator and memory then accumulator add immediate: skip it on carry
// - subtract with borrow of accumulator and memory then add immediate: skip it on no borrow
// - subtract skip form: store difference, skip on borrow, flag kept
// - subtract with borrow: minus source and flag, flag is borrow
// - and of accumulator, pair or wide pair into destination
// - or of accumulator, pair or wide pair into destination
// - exclusive or of accumulator, pair or wide pair into destination
// - rotate accumulator right through the carry flag
// - complement accumulator bitwise
// - increment single register, skip when result zero
// - increment pointer pair, skip when result is 00h
// - increment memory nibble, skip when written value zero
// - decrement single register, skip when result is fh
// - decrement any pair, skip when result is ffh
// - compare register with immediate, skip on match, nothing altered
// - accumulator add immediate: skip on carry, carry flag untouched
`timescale 1ns/1ps
`default_nettype none
module nas_alu
  import nas_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     rstn,
  input  wire nas_req_s req,
  output var  nas_res_s res,
  output var  logic     carry_flag
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    nas_res_s res;
    logic     carry;
    logic     conv_pend;  // previous op set up a conversion pair
    logic     conv_skip;  // skip the following add immediate
  } nas_state_s;

  nas_state_s st;
  nas_state_s next_st;

  // 9-bit add of two bytes and a carry in
  function automatic logic [8:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       ci);
    add8 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction

  // 9-bit subtract, top bit is borrow
  function automatic logic [8:0] sub8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       bi);
    sub8 = {1'b0, a} - {1'b0, b} - {8'h00, bi};
  endfunction

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    logic [8:0] s;
    logic [4:0] n;
    logic [3:0] src;
    s = 9'h000;
    n = 5'h00;
    src = req.imm_sel ? req.nibble : req.nibble;
    next_st = st;
    next_st.res = '0;
    if (req.valid) begin
      next_st.res.valid = 1'b1;
      next_st.conv_pend = 1'b0;
      next_st.conv_skip = 1'b0;
      unique case (req.op)
        NAS_NOP: begin
        end
        NAS_ADDS_A_IMM: begin
          n = {1'b0, req.acc_pair[3:0]} + {1'b0, req.nibble};
          next_st.res.result = {4'h0, n[3:0]};
          // conversion pairing overrides the own skip
          if (st.conv_pend)
            next_st.res.skip = st.conv_skip;
          else
            next_st.res.skip = n[4];
        end
        NAS_ADDS_RP1_XA: begin
          s = add8(req.pair, req.acc_pair, 1'b0);
          next_st.res.result = s[7:0];
          next_st.res.wide = 1'b1;
          next_st.res.skip = s[8];
        end
        NAS_ADD_WITH_CARRY_FLAG_A_MEM: begin
          n = {1'b0, req.acc_pair[3:0]} + {1'b0, req.nibble}
              + {4'h0, st.carry};
          next_st.res.result = {4'h0, n[3:0]};
          next_st.carry = n[4];
          next_st.conv_pend = 1'b1;
          next_st.conv_skip = n[4];
        end
        NAS_ADD_WITH_CARRY_FLAG_XA_RP, NAS_ADD_WITH_CARRY_FLAG_RP1_XA: begin
          s = add8(req.pair, req.acc_pair, st.carry);
          next_st.res.result = s[7:0];
          next_st.res.wide = 1'b1;
          next_st.carry = s[8];
        end
        NAS_SUBTRACT_SKIP_ON_BORROW_A_MEM: begin
          n = {1'b0, req.acc_pair[3:0]} - {1'b0, req.nibble};
          next_st.res.result = {4'h0, n[3:0]};
          next_st.res.skip = n[4];
        end
        NAS_SUBTRACT_SKIP_ON_BORROW_XA_RP: begin
          s = sub8(req.acc_pair, req.pair, 1'b0);
          next_st.res.result = s[7:0];
          next_st.res.wide = 1'b1;
          next_st.res.skip = s[8];
        end
        NAS_SUBTRACT_SKIP_ON_BORROW_RP1_XA: begin
          s = sub8(req.pair, req.acc_pair, 1'b0);
          next_st.res.result = s[7:0];
          next_st.res.wide = 1'b1;
          next_st.res.skip = s[8];
        end
        NAS_SUBTRACT_WITH_BORROW_A_MEM: begin
          n = {1'b0, req.acc_pair[3:0]} - {1'b0, req.nibble}
              - {4'h0, st.carry};
          next_st.res.result = {4'h0, n[3:0]};
          next_st.carry = n[4];
          next_st.conv_pend = 1'b1;
          next_st.conv_skip = ~n[4];
        end
        NAS_SUBTRACT_WITH_BORROW_XA_RP: begin
          s = sub8(req.acc_pair, req.pair, st.carry);
          next_st.res.result = s[7:0];
          next_st.res.wide = 1'b1;
          next_st.carry = s[8];
        end
        NAS_SUBTRACT_WITH_BORROW_RP1_XA: begin
          s = sub8(req.pair, req.acc_pair, st.carry);
          next_st.res.result = s[7:0];
          next_st.res.wide = 1'b1;
          next_st.carry = s[8];
        end
        NAS_AND_A:
          next_st.res.result = {4'h0, req.acc_pair[3:0] & src};
        NAS_AND_XA_RP, NAS_AND_RP1_XA: begin
          next_st.res.result = req.acc_pair & req.pair;
          next_st.res.wide = 1'b1;
        end
        NAS_OR_A:
          next_st.res.result = {4'h0, req.acc_pair[3:0] | src};
        NAS_OR_XA_RP, NAS_OR_RP1_XA: begin
          next_st.res.result = req.acc_pair | req.pair;
          next_st.res.wide = 1'b1;
        end
        NAS_XOR_A:
          next_st.res.result = {4'h0, req.acc_pair[3:0] ^ src};
        NAS_XOR_XA_RP, NAS_XOR_RP1_XA: begin
          next_st.res.result = req.acc_pair ^ req.pair;
          next_st.res.wide = 1'b1;
        end
        NAS_ROTATE_RIGHT: begin
          next_st.res.result = {4'h0, st.carry, req.acc_pair[3:1]};
          next_st.carry = req.acc_pair[0];
        end
        NAS_COMPLEMENT:
          next_st.res.result = {4'h0, ~req.acc_pair[3:0]};
        NAS_INCREMENT_AND_SKIP_REG, NAS_INCREMENT_AND_SKIP_MEM: begin
          n = {1'b0, req.nibble} + 5'h01;
          next_st.res.result = {4'h0, n[3:0]};
          next_st.res.skip = (n[3:0] == NAS_NIB_ZERO);
        end
        NAS_INCREMENT_AND_SKIP_PAIR: begin
          s = add8(req.pair, 8'h01, 1'b0);
          next_st.res.result = s[7:0];
          next_st.res.wide = 1'b1;
          next_st.res.skip = (s[7:0] == NAS_PAIR_ZERO);
        end
        NAS_DECREMENT_AND_SKIP_REG: begin
          n = {1'b0, req.nibble} - 5'h01;
          next_st.res.result = {4'h0, n[3:0]};
          next_st.res.skip = (n[3:0] == NAS_NIB_ALL1);
        end
        NAS_DECREMENT_AND_SKIP_PAIR: begin
          s = sub8(req.pair, 8'h01, 1'b0);
          next_st.res.result = s[7:0];
          next_st.res.wide = 1'b1;
          next_st.res.skip = (s[7:0] == NAS_PAIR_ALL1);
        end
        NAS_SKE_REG: begin
          // compare only: register value passed back unchanged
          next_st.res.result = {4'h0, req.pair[3:0]};
          next_st.res.skip = (req.pair[3:0] == req.nibble);
        end
      endcase
      next_st.res.carry_we = (next_st.carry != st.carry)
                             || req.op inside {NAS_ADD_WITH_CARRY_FLAG_A_MEM,
                                NAS_ADD_WITH_CARRY_FLAG_XA_RP, NAS_ADD_WITH_CARRY_FLAG_RP1_XA,
                                NAS_SUBTRACT_WITH_BORROW_A_MEM, NAS_SUBTRACT_WITH_BORROW_XA_RP,
                                NAS_SUBTRACT_WITH_BORROW_RP1_XA, NAS_ROTATE_RIGHT};
      next_st.res.carry_flag = next_st.carry;
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // skip output handed to the sequencer, which drops the next op
  assign res = st.res;
  assign carry_flag = st.carry;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_skip_keeps_carry;
    @(posedge clock) disable iff (!rstn)
      req.valid && req.op inside {NAS_ADDS_A_IMM, NAS_ADDS_RP1_XA,
        NAS_SUBTRACT_SKIP_ON_BORROW_A_MEM, NAS_SUBTRACT_SKIP_ON_BORROW_XA_RP, NAS_SUBTRACT_SKIP_ON_BORROW_RP1_XA}
      |=> carry_flag == $past(carry_flag);
  endproperty
  a_skip_keeps_carry: assert property (p_skip_keeps_carry)
    else $error("skip form changed carry flag");

  property p_adds_pair_skip;
    @(posedge clock) disable iff (!rstn)
      req.valid && req.op == NAS_ADDS_RP1_XA
      |=> res.skip == ((9'({1'b0, $past(req.pair)})
          + 9'({1'b0, $past(req.acc_pair)})) > 9'h0ff);
  endproperty
  a_adds_pair_skip: assert property (p_adds_pair_skip)
    else $error("pair add skip wrong");

  property p_add_with_carry_flag_wide;
    @(posedge clock) disable iff (!rstn)
      req.valid && req.op == NAS_ADD_WITH_CARRY_FLAG_XA_RP
      |=> {carry_flag, res.result} == 9'({1'b0, $past(req.pair)})
          + 9'({1'b0, $past(req.acc_pair)}) + 9'($past(carry_flag));
  endproperty
  a_add_with_carry_flag_wide: assert property (p_add_with_carry_flag_wide)
    else $error("add with carry wrong");

  property p_conv_pair;
    @(posedge clock) disable iff (!rstn)
      req.valid && req.op == NAS_ADD_WITH_CARRY_FLAG_A_MEM ##1
      req.valid && req.op == NAS_ADDS_A_IMM
      |=> res.skip == $past(carry_flag, 1);
  endproperty
  a_conv_pair: assert property (p_conv_pair)
    else $error("conversion skip not tied to carry");

  property p_subtract_with_borrow_conv;
    @(posedge clock) disable iff (!rstn)
      req.valid && req.op == NAS_SUBTRACT_WITH_BORROW_A_MEM ##1
      req.valid && req.op == NAS_ADDS_A_IMM
      |=> res.skip == !$past(carry_flag, 1);
  endproperty
  a_subtract_with_borrow_conv: assert property (p_subtract_with_borrow_conv)
    else $error("conversion skip not tied to borrow");

  property p_rotate;
    @(posedge clock) disable iff (!rstn)
      req.valid && req.op == NAS_ROTATE_RIGHT
      |=> carry_flag == $past(req.acc_pair[0])
          && res.result[3] == $past(carry_flag);
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("rotate through flag wrong");

  property p_decrement_and_skip_pair;
    @(posedge clock) disable iff (!rstn)
      req.valid && req.op == NAS_DECREMENT_AND_SKIP_PAIR
      |=> res.skip == ($past(req.pair) == 8'h00);
  endproperty
  a_decrement_and_skip_pair: assert property (p_decrement_and_skip_pair)
    else $error("pair decrement skip wrong");

  property p_increment_and_skip_reg;
    @(posedge clock) disable iff (!rstn)
      req.valid && req.op == NAS_INCREMENT_AND_SKIP_REG
      |=> res.skip == ($past(req.nibble) == 4'hf);
  endproperty
  a_increment_and_skip_reg: assert property (p_increment_and_skip_reg)
    else $error("increment skip wrong");

  property p_ske;
    @(posedge clock) disable iff (!rstn)
      req.valid && req.op == NAS_SKE_REG
      |=> res.skip == ($past(req.pair[3:0]) == $past(req.nibble))
          && $stable(carry_flag);
  endproperty
  a_ske: assert property (p_ske)
    else $error("compare skip wrong");

endmodule
`default_nettype wire

/* tb/nas_seq_model.sv */
// sequencer stand-in: counts one dropped instruction per skip request
// assumes the alu result struct is registered on the core clock
`timescale 1ns/1ps
`default_nettype none
module nas_seq_model
  import nas_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire nas_res_s    res,
  output var  logic [15:0] drop_count
);
  // ----------------------------------------------------------------
  // drop bookkeeping
  // ----------------------------------------------------------------
  // a skip costs the next fetched instruction all of its effects
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      drop_count <= 16'h0000;
    end else if (res.valid && res.skip) begin
      drop_count <= drop_count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the nibble alu, corner cases then random
// assumes one request per cycle and results one cycle later
`timescale 1ns/1ps
`default_nettype none
module testbench
  import nas_pkg::*;
;
  logic        clock;
  logic        rstn;
  nas_req_s    req;
  nas_res_s    res;
  logic        carry_flag;
  logic [15:0] drop_count;
  integer      seed;
  int          miscompares;
  int          compares;
  int          ndrop;
  int          i;
  logic [31:0] rnd;
  logic        cy;
  logic        pend;
  logic        pc;
  logic        pv;
  nas_res_s    pe;
  logic [7:0]  pm;

  nas_alu dut (.clock(clock), .rstn(rstn), .req(req), .res(res),
               .carry_flag(carry_flag));
  nas_seq_model seq (.clock(clock), .rstn(rstn), .res(res),
                     .drop_count(drop_count));

  // ----------------------------------------------------------------
  // clock, verdict and comparisons
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task cmp_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task cmp_bit(input logic got, input logic exp);
    cmp_val({15'h0000, got}, {15'h0000, exp});
  endtask

  // ----------------------------------------------------------------
  // expectation
  // ----------------------------------------------------------------
  // m masks the result bits worth checking; a skipped pair partner
  // has no visible effect, so its sum is left unchecked
  function automatic nas_res_s predict(input nas_req_s r, input logic c,
                                       input logic pp, input logic pk,
                                       output logic [7:0] m);
    nas_res_s   e;
    logic       xa;
    logic [7:0] d8;
    logic [7:0] s8;
    logic [8:0] t;
    logic [4:0] n;
    xa = r.op inside {NAS_ADD_WITH_CARRY_FLAG_XA_RP, NAS_SUBTRACT_SKIP_ON_BORROW_XA_RP, NAS_SUBTRACT_WITH_BORROW_XA_RP,
                      NAS_AND_XA_RP, NAS_OR_XA_RP, NAS_XOR_XA_RP};
    d8 = xa ? r.acc_pair : r.pair;
    s8 = xa ? r.pair : r.acc_pair;
    e = '0;
    e.valid = 1'b1;
    e.carry_flag = c;
    t = 9'h000;
    n = {1'b0, r.acc_pair[3:0]};
    case (r.op)
      NAS_ADDS_A_IMM: begin
        n = n + {1'b0, r.nibble};
        e.skip = pp ? pk : n[4];
      end
      NAS_ADDS_RP1_XA: t = {1'b0, d8} + {1'b0, s8};
      NAS_ADD_WITH_CARRY_FLAG_XA_RP, NAS_ADD_WITH_CARRY_FLAG_RP1_XA: t = {1'b0, d8} + {1'b0, s8} + 9'(c);
      NAS_SUBTRACT_SKIP_ON_BORROW_XA_RP, NAS_SUBTRACT_SKIP_ON_BORROW_RP1_XA: t = {1'b0, d8} - {1'b0, s8};
      NAS_SUBTRACT_WITH_BORROW_XA_RP, NAS_SUBTRACT_WITH_BORROW_RP1_XA: t = {1'b0, d8} - {1'b0, s8} - 9'(c);
      NAS_AND_XA_RP, NAS_AND_RP1_XA: t = {1'b0, d8 & s8};
      NAS_OR_XA_RP, NAS_OR_RP1_XA: t = {1'b0, d8 | s8};
      NAS_XOR_XA_RP, NAS_XOR_RP1_XA: t = {1'b0, d8 ^ s8};
      NAS_ADD_WITH_CARRY_FLAG_A_MEM: n = n + {1'b0, r.nibble} + 5'(c);
      NAS_SUBTRACT_SKIP_ON_BORROW_A_MEM, NAS_SUBTRACT_WITH_BORROW_A_MEM: begin
        n = n - {1'b0, r.nibble} - ((r.op == NAS_SUBTRACT_WITH_BORROW_A_MEM) ? 5'(c) : 5'h00);
      end
      NAS_AND_A: n = n & {1'b0, r.nibble};
      NAS_OR_A: n = n | {1'b0, r.nibble};
      NAS_XOR_A: n = n ^ {1'b0, r.nibble};
      NAS_ROTATE_RIGHT: n = {1'b0, c, r.acc_pair[3:1]};
      NAS_COMPLEMENT: n = {1'b0, ~r.acc_pair[3:0]};
      NAS_INCREMENT_AND_SKIP_REG, NAS_INCREMENT_AND_SKIP_MEM: n = {1'b0, r.nibble} + 5'h01;
      NAS_DECREMENT_AND_SKIP_REG: n = {1'b0, r.nibble} - 5'h01;
      NAS_INCREMENT_AND_SKIP_PAIR: t = {1'b0, r.pair} + 9'h001;
      NAS_DECREMENT_AND_SKIP_PAIR: t = {1'b0, r.pair} - 9'h001;
      NAS_SKE_REG: e.skip = (r.pair[3:0] == r.nibble);
      default: n = 5'h00;
    endcase
    e.wide = r.op inside {NAS_ADDS_RP1_XA, NAS_ADD_WITH_CARRY_FLAG_XA_RP, NAS_ADD_WITH_CARRY_FLAG_RP1_XA,
                          NAS_SUBTRACT_SKIP_ON_BORROW_XA_RP, NAS_SUBTRACT_SKIP_ON_BORROW_RP1_XA, NAS_SUBTRACT_WITH_BORROW_XA_RP,
                          NAS_SUBTRACT_WITH_BORROW_RP1_XA, NAS_AND_XA_RP, NAS_AND_RP1_XA,
                          NAS_OR_XA_RP, NAS_OR_RP1_XA, NAS_XOR_XA_RP,
                          NAS_XOR_RP1_XA, NAS_INCREMENT_AND_SKIP_PAIR, NAS_DECREMENT_AND_SKIP_PAIR};
    e.carry_we = r.op inside {NAS_ADD_WITH_CARRY_FLAG_A_MEM, NAS_ADD_WITH_CARRY_FLAG_XA_RP, NAS_ADD_WITH_CARRY_FLAG_RP1_XA,
                              NAS_SUBTRACT_WITH_BORROW_A_MEM, NAS_SUBTRACT_WITH_BORROW_XA_RP, NAS_SUBTRACT_WITH_BORROW_RP1_XA,
                              NAS_ROTATE_RIGHT};
    if (r.op inside {NAS_ADDS_RP1_XA, NAS_SUBTRACT_SKIP_ON_BORROW_XA_RP, NAS_SUBTRACT_SKIP_ON_BORROW_RP1_XA}) begin
      e.skip = t[8];
    end
    if (r.op == NAS_SUBTRACT_SKIP_ON_BORROW_A_MEM) e.skip = n[4];
    if (r.op == NAS_INCREMENT_AND_SKIP_REG || r.op == NAS_INCREMENT_AND_SKIP_MEM) e.skip = n[3:0] == 4'h0;
    if (r.op == NAS_DECREMENT_AND_SKIP_REG) e.skip = n[3:0] == 4'hf;
    if (r.op == NAS_INCREMENT_AND_SKIP_PAIR) e.skip = t[7:0] == 8'h00;
    if (r.op == NAS_DECREMENT_AND_SKIP_PAIR) e.skip = t[7:0] == 8'hff;
    if (e.carry_we) e.carry_flag = e.wide ? t[8] : n[4];
    if (r.op == NAS_ROTATE_RIGHT) e.carry_flag = r.acc_pair[0];
    e.result = e.wide ? t[7:0] : {4'h0, n[3:0]};
    m = e.wide ? 8'hff : 8'h0f;
    if (r.op == NAS_SKE_REG || (pp && r.op == NAS_ADDS_A_IMM && pk)) m = 8'h00;
    return e;
  endfunction

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  // one cycle: present r, then judge what the previous request gave
  task cyc(input nas_req_s r);
    @(posedge clock);
    req <= r;
    #1;
    cmp_bit(res.valid, pv);
    if (pv) begin
      cmp_bit(res.skip, pe.skip);
      cmp_bit(res.carry_we, pe.carry_we);
      if (pm != 8'h00) begin
        cmp_val({8'h00, res.result & pm}, {8'h00, pe.result & pm});
        cmp_bit(res.wide, pe.wide);
      end
    end
    cmp_bit(carry_flag, cy);
    pv = r.valid;
    if (r.valid) begin
      pe = predict(r, cy, pend, pc, pm);
      if (pe.carry_we) cy = pe.carry_flag;
      pend = r.op inside {NAS_ADD_WITH_CARRY_FLAG_A_MEM, NAS_SUBTRACT_WITH_BORROW_A_MEM};
      pc = (r.op == NAS_ADD_WITH_CARRY_FLAG_A_MEM) ? pe.carry_flag : ~pe.carry_flag;
    end
  endtask

  // the slot after a skip is fetched but never executed
  task step(input nas_req_s r);
    if (pv && pe.skip) begin
      ndrop++;
      cyc('0);
    end
    cyc(r);
  endtask

  task go(input nas_op_e o, input logic [3:0] n, input logic [7:0] a,
          input logic [7:0] p);
    nas_req_s r;
    r = '0;
    r.valid = 1'b1;
    r.op = o;
    r.nibble = n;
    r.acc_pair = a;
    r.pair = p;
    step(r);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #100000;
    miscompares++;
    complete_run;
  end

  initial begin
    seed = 32'h5404;
    {miscompares, compares, ndrop} = '0;
    {cy, pend, pc, pv} = 4'h0;
    pe = '0;
    pm = 8'h00;
    req = '0;
    rstn = 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    #1;
    cmp_bit(carry_flag, NAS_CARRY_RST);
    go(NAS_ADDS_RP1_XA, 4'h0, 8'h80, 8'h80);
    go(NAS_ADD_WITH_CARRY_FLAG_A_MEM, 4'h9, 8'h07, 8'h00);
    go(NAS_ADDS_A_IMM, 4'h6, 8'h00, 8'h00);
    go(NAS_ADD_WITH_CARRY_FLAG_A_MEM, 4'h1, 8'h01, 8'h00);
    go(NAS_ADDS_A_IMM, 4'hf, 8'h0f, 8'h00);
    go(NAS_SUBTRACT_WITH_BORROW_A_MEM, 4'h2, 8'h05, 8'h00);
    step('0);
    go(NAS_ADDS_A_IMM, 4'h0, 8'h00, 8'h00);
    go(NAS_SUBTRACT_WITH_BORROW_A_MEM, 4'h6, 8'h05, 8'h00);
    go(NAS_ADDS_A_IMM, 4'hf, 8'h0f, 8'h00);
    go(NAS_SUBTRACT_SKIP_ON_BORROW_XA_RP, 4'h0, 8'h10, 8'h11);
    go(NAS_SUBTRACT_WITH_BORROW_RP1_XA, 4'h0, 8'h01, 8'h00);
    go(NAS_ROTATE_RIGHT, 4'h0, 8'h0a, 8'h00);
    go(NAS_INCREMENT_AND_SKIP_REG, 4'hf, 8'h00, 8'h00);
    go(NAS_INCREMENT_AND_SKIP_PAIR, 4'h0, 8'h00, 8'hff);
    go(NAS_INCREMENT_AND_SKIP_MEM, 4'hf, 8'h00, 8'h00);
    go(NAS_DECREMENT_AND_SKIP_REG, 4'h0, 8'h00, 8'h00);
    go(NAS_DECREMENT_AND_SKIP_PAIR, 4'h0, 8'h00, 8'h00);
    go(NAS_SKE_REG, 4'h5, 8'h00, 8'h05);
    go(NAS_ADDS_A_IMM, 4'h8, 8'h08, 8'h00);
    // every code once, then a long random mix with idle gaps
    for (i = 0; i < 29; i++) begin
      rnd = $random(seed);
      go(nas_op_e'(i), rnd[3:0], rnd[11:4], rnd[19:12]);
    end
    for (i = 0; i < 3000; i++) begin
      rnd = $random(seed);
      req_draw();
    end
    repeat (3) step('0);
    cmp_val(drop_count, 16'(ndrop));
    complete_run;
  end

  task req_draw;
    nas_req_s r;
    r.valid = rnd[26:24] != 3'h0;
    r.op = nas_op_e'(rnd[31:27] % 5'd29);
    r.imm_sel = rnd[23];
    r.nibble = rnd[3:0];
    r.acc_pair = rnd[11:4];
    r.pair = rnd[19:12];
    step(r);
  endtask
endmodule
`default_nettype wire
